// ---- logic/lia_aggregator.sv ----
`timescale 1ns/10ps
// interrupt aggregator: mask, edge select, flags and shared interrupt pin
//
// Operation
// - With configuration 00 or 11 the pin is open drain and pulls low when pending.
// - Configuration 01 gives a push-pull pin that is low when pending.
// - Configuration 10 gives a push-pull pin that is high when pending.
// - All sources share one interrupt pin whose active level means something is pending.
// - Every event latches into its own flag bit in flag register a or b.
// - Every event has its own mask bit in mask register a or b.
// - Events with a live status bit use an edge select bit to decide how they set the flag.
// - A host read of a flag register returns the pin to its inactive level.
// - Fifteen kinds of source are supported.
// - Eight events carry status, flag, edge select and mask bits.
// - Eight events carry only a flag and a mask bit.
// - Mask 0 lets a flag drive the pin, mask 1 blocks it but the flag still latches.
// - Reading a flag register clears the flags it holds.
module lia_aggregator (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// host register access
	input  wire lia_pkg::lia_req_t  req,
	output logic [7:0]              rdata,
	// event sources from the line unit
	input  wire lia_pkg::lia_status_t live_status,
	input  wire logic [5:0]         line_status_b_in,
	input  wire lia_pkg::lia_pulse_t event_pulse,
	// interrupt pin, output level and drive enable
	output logic                    irq_out,
	output logic                    irq_oe,
	// configuration seen by the rest of the chip
	output logic                    chan_mode
);
	// software-written registers, then status history, read data and pin state
	logic [7:0] global_config_reg;
	logic [7:0] irq_mask_a_reg;
	logic [7:0] irq_mask_b_reg;
	logic [7:0] irq_edge_select_reg;
	logic [7:0] status_prev_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       irq_out_reg;
	logic       irq_oe_reg;
	logic       irq_out_next;
	logic       irq_oe_next;

	// one strobe qualified by one register offset, shared by every decoder
	function automatic logic reg_hit(
		input logic       strobe,
		input logic [4:0] addr,
		input logic [4:0] offset
	);
		reg_hit = strobe && (addr == offset);
	endfunction : reg_hit

	// any flag of one register that its mask lets through to the pin
	function automatic logic any_unmasked(
		input logic [7:0] flags,
		input logic [7:0] mask
	);
		any_unmasked = |(flags & ~mask);
	endfunction : any_unmasked

	// decoded accesses
	wire        wr_config  = reg_hit(req.wr, req.addr, lia_pkg::ADDR_GLOBAL_CONFIG);
	wire        wr_mask_a  = reg_hit(req.wr, req.addr, lia_pkg::ADDR_IRQ_MASK_A);
	wire        wr_mask_b  = reg_hit(req.wr, req.addr, lia_pkg::ADDR_IRQ_MASK_B);
	wire        wr_edge    = reg_hit(req.wr, req.addr, lia_pkg::ADDR_IRQ_EDGE_SEL);
	wire        rd_flags_a = reg_hit(req.rd, req.addr, lia_pkg::ADDR_IRQ_FLAGS_A);
	wire        rd_flags_b = reg_hit(req.rd, req.addr, lia_pkg::ADDR_IRQ_FLAGS_B);

	wire  [7:0] status_a_now = live_status;
	wire  [7:0] pulse_bits   = event_pulse;
	wire  [7:0] flags_a;
	wire  [7:0] flags_b;

	// fifteen event kinds, jitter buffer split over and under: 16 flags
	genvar gi;
	generate
		for (gi = 0; gi < lia_pkg::FLAG_BITS; gi++) begin : g_flags
			// status-backed events: flag, edge select, mask
			lia_edge_flag u_flag_a (
				.clock       (clock),
				.sys_rst     (sys_rst),
				.has_status  (1'b1),
				.status_now  (status_a_now[gi]),
				.status_prev (status_prev_reg[gi]),
				.edge_sel    (irq_edge_select_reg[gi]),
				.pulse       (1'b0),
				.clear       (rd_flags_a),
				.flag        (flags_a[gi])
			);
			// pulse-only events: flag and mask only
			lia_edge_flag u_flag_b (
				.clock       (clock),
				.sys_rst     (sys_rst),
				.has_status  (1'b0),
				.status_now  (1'b0),
				.status_prev (1'b0),
				.edge_sel    (1'b0),
				.pulse       (pulse_bits[gi]),
				.clear       (rd_flags_b),
				.flag        (flags_b[gi])
			);
		end
	endgenerate

	// mask 1 blocks the pin only; flags latch regardless
	wire        pending_a = any_unmasked(flags_a, irq_mask_a_reg);
	wire        pending_b = any_unmasked(flags_b, irq_mask_b_reg);
	wire        pending   = pending_a || pending_b;
	// a flag read clears within this cycle, so drop the pin on the same edge
	wire        ack      = rd_flags_a || rd_flags_b;
	wire        active   = pending && !ack;
	wire  [1:0] pin_cfg  = global_config_reg[lia_pkg::IRQ_PIN_LSB +: 2];

	// pin drive style and level
	always_comb begin
		if (!pin_cfg[0] && pin_cfg != lia_pkg::IRQ_PIN_PP_HIGH) begin
			irq_out_next = 1'b0;
			irq_oe_next  = active;
		end else if (pin_cfg == lia_pkg::IRQ_PIN_PP_LOW) begin
			irq_out_next = !active;
			irq_oe_next  = 1'b1;
		end else if (pin_cfg == lia_pkg::IRQ_PIN_PP_HIGH) begin
			irq_out_next = active;
			irq_oe_next  = 1'b1;
		end else begin
			// 11 is not defined: keep the open-drain safe default
			irq_out_next = 1'b0;
			irq_oe_next  = active;
		end
	end

	// read data mux
	always_comb begin
		if (req.addr == lia_pkg::ADDR_GLOBAL_CONFIG) begin
			rdata_next = global_config_reg;
		end else if (req.addr == lia_pkg::ADDR_IRQ_MASK_A) begin
			rdata_next = irq_mask_a_reg;
		end else if (req.addr == lia_pkg::ADDR_IRQ_MASK_B) begin
			rdata_next = irq_mask_b_reg;
		end else if (req.addr == lia_pkg::ADDR_IRQ_EDGE_SEL) begin
			rdata_next = irq_edge_select_reg;
		end else if (req.addr == lia_pkg::ADDR_LINE_STATUS_A) begin
			rdata_next = status_a_now;
		end else if (req.addr == lia_pkg::ADDR_LINE_STATUS_B) begin
			rdata_next = {2'h0, line_status_b_in} & lia_pkg::STATUS_B_MASK;
		end else if (req.addr == lia_pkg::ADDR_IRQ_FLAGS_A) begin
			rdata_next = flags_a;
		end else if (req.addr == lia_pkg::ADDR_IRQ_FLAGS_B) begin
			rdata_next = flags_b;
		end else begin
			rdata_next = 8'h00;
		end
	end

	// pin style and channel mode; unused upper bits always read as zero
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			global_config_reg <= lia_pkg::RST_GLOBAL_CONFIG;
		end else if (wr_config) begin
			global_config_reg <= req.wdata & lia_pkg::GLOBAL_CONFIG_WMASK;
		end
	end

	// mask registers, everything masked out of reset so the pin stays quiet
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_mask_a_reg <= lia_pkg::RST_MASK;
			irq_mask_b_reg <= lia_pkg::RST_MASK;
		end else begin
			if (wr_mask_a) begin
				irq_mask_a_reg <= req.wdata;
			end
			if (wr_mask_b) begin
				irq_mask_b_reg <= req.wdata;
			end
		end
	end

	// edge select register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_edge_select_reg <= lia_pkg::RST_EDGE_SEL;
		end else if (wr_edge) begin
			irq_edge_select_reg <= req.wdata;
		end
	end

	// status history for edge detection; reset to idle so no false edge
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			status_prev_reg <= lia_pkg::RST_STATUS_HIST;
		end else begin
			status_prev_reg <= status_a_now;
		end
	end

	// read data, held until the next read
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_reg <= lia_pkg::RST_RDATA;
		end else if (req.rd) begin
			rdata_reg <= rdata_next;
		end
	end

	// pin registers; pin released at reset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_out_reg <= 1'b0;
			irq_oe_reg  <= 1'b0;
		end else begin
			irq_out_reg <= irq_out_next;
			irq_oe_reg  <= irq_oe_next;
		end
	end

	assign rdata     = rdata_reg;
	assign irq_out   = irq_out_reg;
	assign irq_oe    = irq_oe_reg;
	assign chan_mode = global_config_reg[lia_pkg::CHAN_MODE_BIT];
endmodule : lia_aggregator

// ---- logic/lia_pkg.sv ----
// package for the line unit interrupt aggregator: offsets, fields, types
package lia_pkg;
	// register offsets (5-bit register address space)
	localparam logic [4:0] ADDR_GLOBAL_CONFIG  = 5'h02;
	localparam logic [4:0] ADDR_IRQ_MASK_A     = 5'h14;
	localparam logic [4:0] ADDR_IRQ_MASK_B     = 5'h15;
	localparam logic [4:0] ADDR_IRQ_EDGE_SEL   = 5'h16;
	localparam logic [4:0] ADDR_LINE_STATUS_A  = 5'h17;
	localparam logic [4:0] ADDR_LINE_STATUS_B  = 5'h18;
	localparam logic [4:0] ADDR_IRQ_FLAGS_A    = 5'h19;
	localparam logic [4:0] ADDR_IRQ_FLAGS_B    = 5'h1a;

	// reset values
	localparam logic [7:0] RST_GLOBAL_CONFIG   = 8'h00;
	localparam logic [7:0] RST_MASK            = 8'hff;
	localparam logic [7:0] RST_EDGE_SEL        = 8'h00;
	localparam logic [7:0] RST_FLAGS           = 8'h00;
	localparam logic [7:0] RST_RDATA           = 8'h00;
	localparam logic [7:0] RST_STATUS_HIST     = 8'h00;

	// flag bits held in each flag register
	localparam int         FLAG_BITS           = 8;

	// interrupt pin configuration field and channel mode bit in global_config; status b read mask
	localparam int         IRQ_PIN_LSB         = 0;
	localparam int         CHAN_MODE_BIT       = 2;
	localparam logic [1:0] IRQ_PIN_PP_LOW      = 2'h1;
	localparam logic [1:0] IRQ_PIN_PP_HIGH     = 2'h2;
	localparam logic [7:0] GLOBAL_CONFIG_WMASK = 8'h07;
	localparam logic [7:0] STATUS_B_MASK       = 8'h3f;

	// register access from the host interface
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} lia_req_t;

	// pulse events without a live status bit, in irq_flags_b bit order
	typedef struct packed {
		logic wavegen_overflow;
		logic jitter_buf_over;
		logic jitter_buf_under;
		logic pattern_error;
		logic excess_zero;
		logic code_violation;
		logic second_timer;
		logic counter_overflow;
	} lia_pulse_t;

	// live status bits, in line_status_a bit order
	typedef struct packed {
		logic equalizer_range;
		logic loop_activate_code;
		logic loop_deactivate_code;
		logic pattern_sync;
		logic tx_clock_loss;
		logic driver_fail;
		logic alarm_ind;
		logic signal_loss;
	} lia_status_t;
endpackage : lia_pkg

// ---- logic/lia_edge_flag.sv ----
`timescale 1ns/10ps
// one set-on-event, clear-on-read flag bit with optional edge detection
module lia_edge_flag (
	// clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// event source
	input  wire logic has_status,
	input  wire logic status_now,
	input  wire logic status_prev,
	input  wire logic edge_sel,
	input  wire logic pulse,
	// host clear
	input  wire logic clear,
	// flag
	output logic      flag
);
	logic flag_reg;
	logic flag_next;
	logic rise;
	logic any_edge;
	logic set_evt;

	// edge select 0 means rising only, 1 means both edges
	assign rise     = status_now & ~status_prev;
	assign any_edge = status_now ^ status_prev;
	assign set_evt  = has_status ? (edge_sel ? any_edge : rise) : pulse;
	// set beats clear so an event in the read cycle is kept
	assign flag_next = set_evt | (flag_reg & ~clear);
	assign flag      = flag_reg;

	// flag storage
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
endmodule : lia_edge_flag

// ---- dv/lia_aggregator_sva.sv ----
`timescale 1ns/10ps
// checker for the interrupt aggregator, bound to its ports
module lia_aggregator_chk (
	input wire logic                clock,
	input wire logic                sys_rst,
	input wire lia_pkg::lia_req_t   req,
	input wire logic [7:0]          rdata,
	input wire lia_pkg::lia_status_t live_status,
	input wire lia_pkg::lia_pulse_t event_pulse,
	input wire logic                irq_out,
	input wire logic                irq_oe
);
	logic [1:0] cfg_q;
	logic [7:0] ma_q, mb_q, es_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// shadow of the writable registers, so pin style and masks are known
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_q <= 2'h0;
			ma_q <= 8'hff;
			mb_q <= 8'hff;
			es_q <= 8'h00;
		end else if (req.wr) begin
			if (req.addr == 5'h02) cfg_q <= req.wdata[1:0];
			if (req.addr == 5'h14) ma_q <= req.wdata;
			if (req.addr == 5'h15) mb_q <= req.wdata;
			if (req.addr == 5'h16) es_q <= req.wdata;
		end
	end
	// pending as seen on the pin; style 11 behaves as open drain
	wire act = (cfg_q == 2'h1) ? !irq_out : ((cfg_q == 2'h2) ? irq_out : irq_oe);
	property p_od; (cfg_q == 2'h0 || cfg_q == 2'h3) && $stable(cfg_q) |-> irq_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("open drain pin drove high");
	property p_pp; cfg_q inside {2'h1, 2'h2} && $stable(cfg_q) |-> irq_oe; endproperty
	a_pp: assert property (p_pp) else $error("push-pull pin not driven");
	property p_mask; (ma_q & mb_q) == 8'hff && $stable(ma_q) && $stable(mb_q)
		&& $stable(cfg_q) |-> !act; endproperty
	a_mask: assert property (p_mask) else $error("masked flags drove the pin");
	property p_rise; $rose(live_status.signal_loss) && !ma_q[0] && !req.rd ##1 !req.rd
		|=> act; endproperty
	a_rise: assert property (p_rise) else $error("rising status gave no interrupt");
	property p_fall; $fell(live_status.signal_loss) && es_q[0] && !ma_q[0] && !req.rd
		##1 !req.rd |=> act; endproperty
	a_fall: assert property (p_fall) else $error("falling status gave no interrupt");
	property p_pulse; (event_pulse & ~mb_q) != 8'h00 && !req.rd ##1 !req.rd |=> act;
	endproperty
	a_pulse: assert property (p_pulse) else $error("event pulse gave no interrupt");
	property p_mrd; req.rd && !req.wr && req.addr == 5'h14 |=> rdata == $past(ma_q);
	endproperty
	a_mrd: assert property (p_mrd) else $error("mask read back wrong");
	property p_clr; req.rd && req.addr == 5'h1a && event_pulse == 8'h00 ##1
		event_pulse == 8'h00 ##1 req.rd && req.addr == 5'h1a && event_pulse == 8'h00
		|=> rdata == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("flags kept after read");
	property p_hold; act && !req.rd && !req.wr && !$past(req.rd) && !$past(req.wr)
		|=> act; endproperty
	a_hold: assert property (p_hold) else $error("pin dropped while pending");
endmodule : lia_aggregator_chk

bind lia_aggregator lia_aggregator_chk u_chk (.clock(clock), .sys_rst(sys_rst), .req(req),
	.rdata(rdata), .live_status(live_status), .event_pulse(event_pulse), .irq_out(irq_out),
	.irq_oe(irq_oe));

// ---- dv/lia_host_model.sv ----
`timescale 1ns/10ps
// host model: register accesses and the pulled-up interrupt wire
module lia_host_model (
	// clock
	input  wire logic         clock,
	// register request towards the device
	output lia_pkg::lia_req_t req,
	// pin as driven, and the wire the host sees
	input  wire logic         irq_out,
	input  wire logic         irq_oe,
	output logic              irq_wire
);
	// pull-up holds the wire high whenever nothing drives it
	assign irq_wire = irq_oe ? irq_out : 1'b1;
	initial req = '0;
	// held across one sampling edge; released lines show inverted junk
	task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : access
endmodule : lia_host_model

// ---- dv/line_unit_interrupt_aggregator_tb_top.sv ----
`timescale 1ns/10ps
// bench top: host model, aggregator, read watcher and scenarios
module line_unit_interrupt_aggregator_tb_top;
	logic                 clock, sys_rst, rd_d, irq_out, irq_oe, irq_wire, chan_mode;
	logic [1:0]           cfg;
	logic [5:0]           line_status_b_in;
	logic [7:0]           rdata, p;
	logic [7:0]           exp_q[$];
	int                   mismatches, n_compared;
	lia_pkg::lia_status_t live_status;
	lia_pkg::lia_pulse_t  event_pulse;
	lia_pkg::lia_req_t    req;
	lia_host_model host (.clock(clock), .req(req), .irq_out(irq_out), .irq_oe(irq_oe),
		.irq_wire(irq_wire));
	lia_aggregator uut (.clock(clock), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.live_status(live_status), .line_status_b_in(line_status_b_in),
		.event_pulse(event_pulse), .irq_out(irq_out), .irq_oe(irq_oe), .chan_mode(chan_mode));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic cmp(input logic [7:0] got, input logic [7:0] want);
		n_compared++;
		if (got !== want) begin
			mismatches++;
			$display("[FAIL] %0t read %h, wanted %h", $time, got, want);
		end
	endtask : cmp
	// open drain and push-pull low both read 0 on the wire when active
	task automatic chk_pin(input logic act);
		n_compared++;
		if (irq_wire !== ((cfg == 2'h2) ? act : !act)) begin
			mismatches++;
			$display("[FAIL] %0t interrupt pin at wrong level", $time);
		end
	endtask : chk_pin
	task automatic rd(input logic [4:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		host.access(1'b0, a, 8'h00);
	endtask : rd
	task automatic wrap_up();
		if (exp_q.size() != 0) begin
			mismatches++;
			$display("[FAIL] %0t %0d reads never answered", $time, exp_q.size());
		end
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	// rdata answers one edge after the read, so look in the following low phase
	always @(posedge clock) rd_d <= req.rd;
	always @(negedge clock) begin
		if (rd_d === 1'b1 && exp_q.size() > 0)
			cmp(rdata, exp_q.pop_front());
	end
	// reset values, unmapped and read-only places, edge select, pin styles, masking
	initial begin
		sys_rst = 1'b1;
		cfg = 2'h0;
		live_status = '0;
		event_pulse = '0;
		line_status_b_in = '0;
		mismatches = 0;
		n_compared = 0;
		void'($urandom(24));
		tick(4);
		sys_rst <= 1'b0;
		rd(5'h14, 8'hff);
		rd(5'h15, 8'hff);
		rd(5'h16, 8'h00);
		rd(5'h1a, 8'h00);
		rd(5'h05, 8'h00);
		p = 8'($urandom) & 8'h3f;
		line_status_b_in <= p[5:0];
		rd(5'h18, p);
		host.access(1'b1, 5'h17, 8'hff);
		rd(5'h17, 8'h00);
		host.access(1'b1, 5'h14, 8'h00);
		host.access(1'b1, 5'h15, 8'h00);
		for (int e = 0; e < 2; e++) begin
			host.access(1'b1, 5'h16, 8'(e));
			@(posedge clock);
			live_status <= 8'h01;
			tick(2);
			@(negedge clock);
			chk_pin(1'b1);
			rd(5'h19, 8'h01);
			@(negedge clock);
			chk_pin(1'b0);
			@(posedge clock);
			live_status <= 8'h00;
			tick(3);
			rd(5'h19, 8'(e));
		end
		for (int c = 0; c < 3; c++) begin
			cfg = 2'(c);
			host.access(1'b1, 5'h02, 8'(c));
			p = 8'($urandom) | 8'h01;
			@(posedge clock);
			event_pulse <= p;
			@(posedge clock);
			event_pulse <= '0;
			tick(1);
			@(negedge clock);
			chk_pin(1'b1);
			rd(5'h1a, p);
			rd(5'h1a, 8'h00);
		end
		host.access(1'b1, 5'h02, 8'hfe);
		rd(5'h02, 8'h06);
		cmp({7'h00, chan_mode}, 8'h01);
		host.access(1'b1, 5'h15, 8'hff);
		@(posedge clock);
		event_pulse <= 8'h80;
		@(posedge clock);
		event_pulse <= '0;
		tick(1);
		@(negedge clock);
		chk_pin(1'b0);
		rd(5'h1a, 8'h80);
		tick(2);
		wrap_up();
	end
endmodule : line_unit_interrupt_aggregator_tb_top
